// ===== hw/mce_pkg.sv
// constants and carrier types for the msi configuration export block
// Notes on behaviour
// - message data as programmed by configuration writes appears on its own 16-bit output.
// - a 13-bit bus/device number, captured from the link or programmed, is output.
// - per-vector masking capable bit of the control value always reads zero.
// - control bit 7 reports whether 64-bit message addresses can be sent.
// - allocated-vector codes 000..101 mean 1..32 vectors; 110 and 111 are never used.
// - bits 3 to 1 report requested vectors with the same power-of-two code.
// - no message request is issued in the cycle after one in which the enable bit is zero and the clock enable is high.
// - the whole 16-bit control value is driven out to the application logic.
// - the upper 32 address bits are output for 64-bit message addresses.
package mce_pkg;

   // configuration byte addresses (dword aligned)
   localparam logic [11:0] BUSDEV_OFFSET   = 12'h008;
   localparam logic [11:0] MSI_CAP_OFFSET  = 12'h050;
   localparam logic [11:0] MSI_ADDR_HI_OFF = 12'h058;
   localparam logic [11:0] MSI_DATA64_OFF  = 12'h05c;
   localparam logic [11:0] MSI_DATA32_OFF  = 12'h058;

   // control value field positions
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_MMC_LSB    = 1;
   localparam int CTRL_MME_LSB    = 4;
   localparam int CTRL_CAP64_BIT  = 7;
   localparam int CTRL_MASK_BIT   = 8;
   localparam int CTRL_RSVD_LSB   = 9;
   localparam int CTRL_WORD_LSB   = 16;

   // fixed capability settings of this function
   localparam logic       CAP_64BIT     = 1'b1;
   localparam logic [2:0] MMC_REQUESTED = 3'h5;
   localparam logic [2:0] MME_LAST_OK   = 3'h5;

   // reset values
   localparam logic [15:0] CTRL_RESET   = {7'h00, 1'b0, CAP_64BIT, 3'h0, MMC_REQUESTED, 1'b0};
   localparam logic [15:0] DATA_RESET   = 16'h0000;
   localparam logic [31:0] ADDR_RESET   = 32'h0000_0000;
   localparam logic [12:0] BUSDEV_RESET = 13'h0000;

   typedef struct packed {
      logic        wr;
      logic [11:0] addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } mce_cfg_wr_type;

   typedef struct packed {
      logic        valid;
      logic [12:0] value;
   } mce_capture_type;

   // merge byte-enabled write data into an old dword
   function automatic logic [31:0] mce_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : mce_merge

endpackage : mce_pkg

// ===== hw/mce_req_gate.sv
// gate that passes application message requests only while messages are enabled
module mce_req_gate
   import mce_pkg::*;
(
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_reset,
   input  wire logic i_ce,
   // control
   input  wire logic i_enable,
   input  wire logic i_req,
   // result
   output logic      o_req,
   output logic      o_blocked
);

   typedef struct packed {
      logic req;
      logic blocked;
   } mce_gate_state_type;

   mce_gate_state_type state;
   mce_gate_state_type next_state;

   always_comb begin
      next_state         = state;
      next_state.req     = i_req & i_enable;
      next_state.blocked = i_req & ~i_enable;
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state <= '0;
      end else if (i_ce) begin
         state <= next_state;
      end
   end

   assign o_req     = state.req;
   assign o_blocked = state.blocked;

   chk_gate_no_req: assert property (@(posedge i_clk) disable iff (i_reset)
      i_ce && !i_enable |=> !o_req) else $error("request passed while disabled");
   chk_gate_passes: assert property (@(posedge i_clk) disable iff (i_reset)
      i_ce && i_enable && i_req |=> o_req && !o_blocked) else $error("enabled request lost");

endmodule : mce_req_gate

// ===== hw/mce_export.sv
// msi configuration registers exported to the application logic
module mce_export
   import mce_pkg::*;
(
   // clock and reset
   input  wire logic            i_clk,
   input  wire logic            i_reset,
   input  wire logic            i_ce,
   // configuration writes from the host
   input  wire mce_cfg_wr_type  i_cfg,
   // bus/device number seen on the link
   input  wire mce_capture_type i_capture,
   // application message request
   input  wire logic            i_app_msi_req,
   // exported values
   output logic [15:0]          o_msi_data,
   output logic [12:0]          o_busdev,
   output logic [15:0]          o_msi_ctrl,
   output logic [31:0]          o_msi_addr_hi,
   // gated request
   output logic                 o_msi_req,
   output logic                 o_msi_blocked
);

   typedef struct packed {
      logic [15:0] ctrl;
      logic [31:0] addr_hi;
      logic [15:0] data;
      logic [12:0] busdev;
   } mce_state_type;

   mce_state_type state;
   mce_state_type next_state;

   logic [31:0] ctrl_word;
   logic [31:0] ctrl_merged;
   logic [31:0] data_merged;
   logic [31:0] busdev_merged;
   logic [31:0] addr_merged;
   logic [11:0] data_offset;
   logic [2:0]  mme_new;

   // message data moves down a dword when only 32-bit addresses are supported
   assign data_offset = CAP_64BIT ? MSI_DATA64_OFF : MSI_DATA32_OFF;

   always_comb begin
      next_state    = state;
      ctrl_word     = {state.ctrl, 16'h0000};
      ctrl_merged   = mce_merge(ctrl_word, i_cfg.wdata, i_cfg.be);
      data_merged   = mce_merge({16'h0000, state.data}, i_cfg.wdata, i_cfg.be);
      busdev_merged = mce_merge({19'h00000, state.busdev}, i_cfg.wdata, i_cfg.be);
      addr_merged   = mce_merge(state.addr_hi, i_cfg.wdata, i_cfg.be);
      mme_new       = ctrl_merged[CTRL_WORD_LSB + CTRL_MME_LSB +: 3];
      // link capture first; an explicit programming write in the same cycle wins
      if (i_capture.valid) begin
         next_state.busdev = i_capture.value;
      end
      if (i_cfg.wr) begin
         if (i_cfg.addr == MSI_CAP_OFFSET) begin
            // only enable and allocated count are writable; the rest stays constant
            next_state.ctrl[CTRL_ENABLE_BIT] = ctrl_merged[CTRL_WORD_LSB + CTRL_ENABLE_BIT];
            // reserved codes are refused so the count always stays meaningful
            if (mme_new <= MME_LAST_OK) begin
               next_state.ctrl[CTRL_MME_LSB +: 3] = mme_new;
            end
         end
         if (CAP_64BIT && i_cfg.addr == MSI_ADDR_HI_OFF) begin
            next_state.addr_hi = addr_merged;
         end
         if (i_cfg.addr == data_offset) begin
            next_state.data = data_merged[15:0];
         end
         if (i_cfg.addr == BUSDEV_OFFSET) begin
            next_state.busdev = busdev_merged[12:0];
         end
      end
      // read-only fields are re-asserted every cycle
      next_state.ctrl[CTRL_MASK_BIT]      = 1'b0;
      next_state.ctrl[CTRL_CAP64_BIT]     = CAP_64BIT;
      next_state.ctrl[CTRL_MMC_LSB +: 3]  = MMC_REQUESTED;
      next_state.ctrl[15:CTRL_RSVD_LSB]   = '0;
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state.ctrl    <= CTRL_RESET;
         state.addr_hi <= ADDR_RESET;
         state.data    <= DATA_RESET;
         state.busdev  <= BUSDEV_RESET;
      end else if (i_ce) begin
         state <= next_state;
      end
   end

   assign o_msi_data    = state.data;
   assign o_busdev      = state.busdev;
   assign o_msi_ctrl    = state.ctrl;
   assign o_msi_addr_hi = state.addr_hi;

   // requests see the enable bit as registered, one cycle behind a write
   mce_req_gate mce_req_gate_inst (
      .i_clk     (i_clk),
      .i_reset   (i_reset),
      .i_ce      (i_ce),
      .i_enable  (state.ctrl[CTRL_ENABLE_BIT]),
      .i_req     (i_app_msi_req),
      .o_req     (o_msi_req),
      .o_blocked (o_msi_blocked)
   );

   // one write decode shared by the checks below
   function automatic logic cfg_hit(input mce_cfg_wr_type c, input logic [11:0] a);
      return c.wr && (c.addr == a);
   endfunction : cfg_hit

   // read-only parts of the control value
   chk_mask_bit_zero: assert property (@(posedge i_clk) disable iff (i_reset)
      o_msi_ctrl[CTRL_MASK_BIT] == 1'b0) else $error("mask capable bit set");
   chk_cap64_bit: assert property (@(posedge i_clk) disable iff (i_reset)
      o_msi_ctrl[CTRL_CAP64_BIT] == CAP_64BIT) else $error("64-bit capability wrong");
   chk_mmc_field: assert property (@(posedge i_clk) disable iff (i_reset)
      o_msi_ctrl[CTRL_MMC_LSB +: 3] == MMC_REQUESTED) else $error("requested count wrong");
   chk_reserved_zero: assert property (@(posedge i_clk) disable iff (i_reset)
      o_msi_ctrl[15:CTRL_RSVD_LSB] == '0) else $error("reserved control bits set");

   // allocated count: legal codes land, reserved codes leave the field alone
   chk_mme_legal: assert property (@(posedge i_clk) disable iff (i_reset)
      o_msi_ctrl[CTRL_MME_LSB +: 3] <= MME_LAST_OK) else $error("reserved vector code held");
   chk_mme_write: assert property (@(posedge i_clk) disable iff (i_reset)
      i_ce && cfg_hit(i_cfg, MSI_CAP_OFFSET) && i_cfg.be[2]
      && i_cfg.wdata[CTRL_WORD_LSB + CTRL_MME_LSB +: 3] <= MME_LAST_OK
      |=> o_msi_ctrl[CTRL_MME_LSB +: 3] == $past(i_cfg.wdata[CTRL_WORD_LSB + CTRL_MME_LSB +: 3]))
      else $error("allocated count not written");
   chk_mme_refused: assert property (@(posedge i_clk) disable iff (i_reset)
      i_ce && cfg_hit(i_cfg, MSI_CAP_OFFSET) && i_cfg.be[2]
      && i_cfg.wdata[CTRL_WORD_LSB + CTRL_MME_LSB +: 3] > MME_LAST_OK
      |=> $stable(o_msi_ctrl[CTRL_MME_LSB +: 3])) else $error("reserved count accepted");
   chk_enable_write: assert property (@(posedge i_clk) disable iff (i_reset)
      i_ce && cfg_hit(i_cfg, MSI_CAP_OFFSET) && i_cfg.be[2]
      |=> o_msi_ctrl[CTRL_ENABLE_BIT] == $past(i_cfg.wdata[CTRL_WORD_LSB]))
      else $error("enable bit not written");
   chk_ctrl_hold: assert property (@(posedge i_clk) disable iff (i_reset)
      i_ce && !cfg_hit(i_cfg, MSI_CAP_OFFSET)
      |=> $stable(o_msi_ctrl)) else $error("control moved without a write");

   // message data and upper address
   chk_data_write: assert property (@(posedge i_clk) disable iff (i_reset)
      i_ce && cfg_hit(i_cfg, data_offset) && i_cfg.be[1:0] == 2'h3
      |=> o_msi_data == $past(i_cfg.wdata[15:0])) else $error("message data not written");
   chk_data_low_byte: assert property (@(posedge i_clk) disable iff (i_reset)
      i_ce && cfg_hit(i_cfg, data_offset) && i_cfg.be[1:0] == 2'h1
      |=> o_msi_data[7:0] == $past(i_cfg.wdata[7:0]) && $stable(o_msi_data[15:8]))
      else $error("byte enables ignored on data");
   chk_data_hold: assert property (@(posedge i_clk) disable iff (i_reset)
      i_ce && !cfg_hit(i_cfg, data_offset)
      |=> $stable(o_msi_data)) else $error("message data moved without a write");
   chk_addr_write: assert property (@(posedge i_clk) disable iff (i_reset)
      i_ce && cfg_hit(i_cfg, MSI_ADDR_HI_OFF) && i_cfg.be == 4'hf
      |=> o_msi_addr_hi == $past(i_cfg.wdata)) else $error("upper address not written");
   chk_addr_hold: assert property (@(posedge i_clk) disable iff (i_reset)
      i_ce && !cfg_hit(i_cfg, MSI_ADDR_HI_OFF)
      |=> $stable(o_msi_addr_hi)) else $error("upper address moved without a write");

   // bus/device number: capture, programming write and hold
   chk_busdev_capture: assert property (@(posedge i_clk) disable iff (i_reset)
      i_ce && i_capture.valid && !cfg_hit(i_cfg, BUSDEV_OFFSET)
      |=> o_busdev == $past(i_capture.value)) else $error("bus/device not captured");
   chk_busdev_write: assert property (@(posedge i_clk) disable iff (i_reset)
      i_ce && cfg_hit(i_cfg, BUSDEV_OFFSET) && i_cfg.be[1:0] == 2'h3
      |=> o_busdev == $past(i_cfg.wdata[12:0])) else $error("bus/device write lost");
   chk_busdev_hold: assert property (@(posedge i_clk) disable iff (i_reset)
      i_ce && !i_capture.valid && !cfg_hit(i_cfg, BUSDEV_OFFSET)
      |=> $stable(o_busdev)) else $error("bus/device moved on its own");

   // request gating follows the registered enable bit
   chk_req_disabled: assert property (@(posedge i_clk) disable iff (i_reset)
      i_ce && !o_msi_ctrl[CTRL_ENABLE_BIT] |=> !o_msi_req) else $error("request while disabled");
   chk_req_blocked: assert property (@(posedge i_clk) disable iff (i_reset)
      i_ce && i_app_msi_req && !o_msi_ctrl[CTRL_ENABLE_BIT]
      |=> o_msi_blocked && !o_msi_req) else $error("disabled request not flagged");
   chk_req_passes: assert property (@(posedge i_clk) disable iff (i_reset)
      i_ce && i_app_msi_req && o_msi_ctrl[CTRL_ENABLE_BIT]
      |=> o_msi_req && !o_msi_blocked) else $error("enabled request not passed");
   chk_req_idle: assert property (@(posedge i_clk) disable iff (i_reset)
      i_ce && !i_app_msi_req |=> !o_msi_req && !o_msi_blocked) else $error("request out of nothing");

   // clock enable and reset
   chk_freeze: assert property (@(posedge i_clk) disable iff (i_reset)
      !i_ce |=> $stable(o_msi_ctrl) && $stable(o_msi_data)) else $error("state moved without enable");
   chk_freeze_rest: assert property (@(posedge i_clk) disable iff (i_reset)
      !i_ce |=> $stable(o_msi_addr_hi) && $stable(o_busdev) && $stable(o_msi_req) && $stable(o_msi_blocked))
      else $error("outputs moved without enable");
   chk_reset_values: assert property (@(posedge i_clk)
      i_reset |=> o_msi_ctrl == CTRL_RESET && o_msi_data == DATA_RESET && o_msi_addr_hi == ADDR_RESET
      && o_busdev == BUSDEV_RESET && !o_msi_req && !o_msi_blocked) else $error("reset values wrong");

   cov_enable_set: cover property (@(posedge i_clk) disable iff (i_reset)
      $rose(o_msi_ctrl[CTRL_ENABLE_BIT]));
   cov_req_passed: cover property (@(posedge i_clk) disable iff (i_reset) o_msi_req);
   cov_req_blocked: cover property (@(posedge i_clk) disable iff (i_reset) o_msi_blocked);
   cov_mme_largest: cover property (@(posedge i_clk) disable iff (i_reset)
      o_msi_ctrl[CTRL_MME_LSB +: 3] == MME_LAST_OK);
   cov_mme_refused: cover property (@(posedge i_clk) disable iff (i_reset)
      i_ce && cfg_hit(i_cfg, MSI_CAP_OFFSET) && i_cfg.be[2]
      && i_cfg.wdata[CTRL_WORD_LSB + CTRL_MME_LSB +: 3] > MME_LAST_OK);

endmodule : mce_export

// ===== tb/mce_app_model.sv
// application-side model that raises message requests
module mce_app_model (
   // control from the bench
   input  wire logic        i_go,
   input  wire logic        i_rude,
   input  wire logic [15:0] i_ctrl,
   // request to the block
   output logic             o_req
);
   timeunit 1ns;
   timeprecision 1ps;
   // no per-vector masking kept here; rude mode ignores enable on purpose
   assign o_req = i_go & (i_ctrl[0] | i_rude);
endmodule : mce_app_model

// ===== tb/mce_export_bench.sv
// self-checking bench for the msi configuration export block
module mce_export_bench;
   import mce_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
   $display("unexpected at %0t: got %h want %h", $time, a, e); end end
   logic            i_clk, i_reset, i_ce, go, rude, req, msi_req, blocked;
   mce_cfg_wr_type  cfg;
   mce_capture_type cap;
   logic [15:0]     msi_data, msi_ctrl;
   logic [12:0]     busdev;
   logic [31:0]     addr_hi;
   logic [2:0]      fld;
   int              miscompares, n_checks;

   mce_export mce_export_inst (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_cfg(cfg),
      .i_capture(cap), .i_app_msi_req(req), .o_msi_data(msi_data), .o_busdev(busdev),
      .o_msi_ctrl(msi_ctrl), .o_msi_addr_hi(addr_hi), .o_msi_req(msi_req), .o_msi_blocked(blocked));
   mce_app_model mce_app_model_inst (.i_go(go), .i_rude(rude), .i_ctrl(msi_ctrl), .o_req(req));

   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk);
   endtask : cyc
   // write stays asserted so calls run back to back
   task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
      cfg = '{1'b1, a, be, d};
      cyc(1);
   endtask : wr
   task automatic done(input string s);
      cfg.wr = 1'b0;
      cap.valid = 1'b0;
      go = 1'b0;
      cyc(1);
      $display("test %s done", s);
   endtask : done
   task automatic close_out;
      $display("checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out

   task automatic t_reset;
      `CHK(msi_ctrl, 16'h008a)
      `CHK({msi_data, addr_hi, busdev, msi_req, blocked}, 63'h0)
      done("reset");
   endtask : t_reset
   // reserved codes keep the old field; other bits are read-only
   task automatic t_ctrl;
      fld = 3'h0;
      for (int c = 0; c < 8; c++) begin
         wr(MSI_CAP_OFFSET, 4'hc, {8'hff, 1'b1, c[2:0], 3'h0, c[0], 16'hffff});
         if (c <= 5) fld = c[2:0];
         `CHK(msi_ctrl, {8'h00, CAP_64BIT, fld, MMC_REQUESTED, c[0]})
      end
      done("ctrl");
   endtask : t_ctrl
   task automatic t_data;
      wr(MSI_DATA64_OFF, 4'h1, 32'hffff_ff5a);
      wr(MSI_DATA64_OFF, 4'h2, 32'h00a5_c300);
      `CHK(msi_data, 16'hc35a)
      wr(MSI_ADDR_HI_OFF, 4'hf, 32'h89ab_cdef);
      `CHK(addr_hi, 32'h89ab_cdef)
      wr(12'h0a0, 4'hf, 32'h0);
      `CHK({msi_data, addr_hi}, 48'hc35a_89ab_cdef)
      done("data");
   endtask : t_data
   task automatic t_busdev;
      cap = '{1'b1, 13'h1abc};
      cyc(1);
      `CHK(busdev, 13'h1abc)
      cap.value = 13'h0fff;
      wr(BUSDEV_OFFSET, 4'h3, 32'hffff_e123);
      `CHK(busdev, 13'h0123)
      done("busdev");
   endtask : t_busdev
   task automatic t_req;
      wr(MSI_CAP_OFFSET, 4'h4, 32'h0);
      done("disable");
      go = 1'b1;
      rude = 1'b1;
      cyc(1);
      `CHK({msi_req, blocked}, 2'b01)
      go = 1'b0;
      rude = 1'b0;
      wr(MSI_CAP_OFFSET, 4'h4, 32'h0001_0000);
      cfg.wr = 1'b0;
      go = 1'b1;
      cyc(1);
      `CHK({msi_req, blocked}, 2'b10)
      cyc(1);
      `CHK({msi_req, blocked}, 2'b10)
      done("req");
   endtask : t_req
   // low enable freezes writes, captures and the gate; reset still acts
   task automatic t_freeze;
      i_ce = 1'b0;
      cap = '{1'b1, 13'h0555};
      go = 1'b1;
      wr(MSI_CAP_OFFSET, 4'h4, 32'h0000_0000);
      `CHK(msi_ctrl, 16'h008b)
      `CHK(busdev, 13'h0123)
      `CHK({msi_req, blocked}, 2'b00)
      i_ce = 1'b1;
      cyc(1);
      `CHK(msi_ctrl, 16'h008a)
      `CHK(busdev, 13'h0555)
      `CHK({msi_req, blocked}, 2'b10)
      cyc(1);
      `CHK({msi_req, blocked}, 2'b00)
      i_reset = 1'b1;
      i_ce = 1'b0;
      cyc(1);
      i_reset = 1'b0;
      i_ce = 1'b1;
      `CHK(msi_ctrl, 16'h008a)
      `CHK({msi_data, addr_hi, busdev, msi_req, blocked}, 63'h0)
      done("freeze");
   endtask : t_freeze

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   initial begin
      #100us;
      miscompares++;
      close_out();
   end
   initial begin
      i_reset = 1'b1;
      i_ce = 1'b1;
      cfg = '0;
      cap = '0;
      go = 1'b0;
      rude = 1'b0;
      cyc(5);
      i_reset = 1'b0;
      t_reset();
      t_ctrl();
      t_data();
      t_busdev();
      t_req();
      t_freeze();
      close_out();
   end
endmodule : mce_export_bench
